// *** core/gpm_top.sv ***
// Pin function mux and pad control for three 8-slot ports, APB3 register slave.
// Assumes pin inputs synchronous to CLK; SOFT_RST is a one-cycle pulse from the
// watchdog or software reset logic; PLL_CLK_MODE comes from the PLL control register.

`include "gpm_params.svh"

module gpm_top
   import gpm_pkg::*;
#(
   parameter logic [23:0] PIN_MASK = `GPM_PIN_MASK
) (
   input  wire logic        CLK,
   input  wire logic        RST_B,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [31:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        SOFT_RST,
   input  wire logic        POWER_SAVE,
   input  wire logic [1:0]  PLL_CLK_MODE,
   input  wire logic        CORE_CLK_OUT,
   input  wire logic [23:0] PIN_I,
   input  wire gpm_alt_t    ALT1,
   input  wire gpm_alt_t    ALT2,
   input  wire gpm_alt_t    ALT3,
   output gpm_pad_t         PAD,
   output logic      [23:0] PIN_IN,
   output logic      [3:0]  EXT_IRQ,
   output logic             PIN12_CLK_IN
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [31:0] fsel       [3];
   logic [31:0] par        [3];
   logic [15:0] dat_ctl    [3];
   logic [7:0]  rst_state  [3];
   logic [2:0]  drv_locked;
   logic        retain;
   logic        strap_pend;
   logic        soft_clear;
   logic        bus_access;
   logic        bus_wr;
   logic [31:0] par_mask   [3];
   logic [31:0] par_rst    [3];
   logic [31:0] fsel_rst   [3];
   logic [31:0] rd_data;
   logic        rd_hit;

   // ----------------------------------------------------------------
   // Per-port constants
   // ----------------------------------------------------------------
   // Read masks hide fixed bits, so a reset value that sets one still reads 00.
   assign par_mask[0] = `GPM_PAR0_MASK;
   assign par_mask[1] = `GPM_PAR1_MASK;
   assign par_mask[2] = `GPM_PAR2_MASK;
   assign par_rst[0]  = `GPM_PAR0_RST;
   assign par_rst[1]  = `GPM_PAR1_RST;
   assign par_rst[2]  = `GPM_PAR2_RST;
   assign fsel_rst[0] = `GPM_FSEL0_RST;
   assign fsel_rst[1] = `GPM_FSEL1_RST;
   assign fsel_rst[2] = `GPM_FSEL2_RST;

   assign soft_clear = SOFT_RST & ~retain;
   // power saving ignored
   // POWER_SAVE deliberately steers nothing: pads keep every bit of state.

   // ----------------------------------------------------------------
   // APB handshake
   // ----------------------------------------------------------------
   // One wait state: PREADY is registered so read data is settled with it.
   // Unmapped addresses answer with PSLVERR and leave every register alone.
   assign bus_access = PSEL & PENABLE & PREADY;
   assign bus_wr     = bus_access & PWRITE;

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         PREADY <= 1'b0;
      end else begin
         PREADY <= PSEL & PENABLE & ~PREADY;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else if (PSEL & PENABLE & ~PREADY) begin
         PRDATA  <= PWRITE ? 32'h0000_0000 : rd_data;
         PSLVERR <= ~rd_hit;
      end else begin
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   // Set and clear data registers are left undecoded and answer with an error.
   always_comb begin
      rd_hit  = 1'b1;
      rd_data = 32'h0000_0000;
      if (PADDR == `GPM_ADDR_FSEL0) begin
         rd_data = fsel[0];
      end else if (PADDR == `GPM_ADDR_FSEL1) begin
         rd_data = fsel[1];
      end else if (PADDR == `GPM_ADDR_FSEL2) begin
         rd_data = fsel[2];
      end else if (PADDR == `GPM_ADDR_PAR0) begin
         rd_data = par[0] & par_mask[0];
      end else if (PADDR == `GPM_ADDR_PAR1) begin
         rd_data = par[1] & par_mask[1];
      end else if (PADDR == `GPM_ADDR_PAR2) begin
         rd_data = par[2] & par_mask[2];
      end else if (PADDR == `GPM_ADDR_DAT0) begin
         rd_data = {dat_ctl[0], rst_state[0], PIN_IN[7:0]};
      end else if (PADDR == `GPM_ADDR_DAT1) begin
         rd_data = {dat_ctl[1], rst_state[1], PIN_IN[15:8]};
      end else if (PADDR == `GPM_ADDR_DAT2) begin
         rd_data = {dat_ctl[2], rst_state[2], PIN_IN[23:16]};
      end else if (PADDR == `GPM_ADDR_RESET_CONFIGURATION) begin
         rd_data = {31'h0000_0000, retain};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Reset configuration and boot strap
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         retain <= 1'b0;
      end else if (bus_wr && PADDR == `GPM_ADDR_RESET_CONFIGURATION) begin
         retain <= PWDATA[`GPM_RETAIN_BIT];
      end
   end

   // Strap is caught at the first edge after release, never under reset.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         strap_pend <= 1'b1;
      end else begin
         strap_pend <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Function select registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         fsel[0] <= `GPM_FSEL0_RST;
         fsel[1] <= `GPM_FSEL1_RST;
         fsel[2] <= `GPM_FSEL2_RST;
      end else begin
         for (int p = 0; p < 3; p++) begin
            if (soft_clear) begin
               fsel[p] <= fsel_rst[p];
            end else if (bus_wr && PADDR == `GPM_ADDR_FSEL0 + 32'(4 * p)) begin
               fsel[p] <= PWDATA & `GPM_FSEL_MASK;
            end
         end
         if (strap_pend | soft_clear) begin
            fsel[0][15:0] <= PIN_I[0] ? `GPM_FSEL_DBG_RST : 16'h0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pad parameter registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         par[0]     <= `GPM_PAR0_RST;
         par[1]     <= `GPM_PAR1_RST;
         par[2]     <= `GPM_PAR2_RST;
         drv_locked <= 3'h0;
      end else begin
         for (int p = 0; p < 3; p++) begin
            if (soft_clear) begin
               par[p]        <= par_rst[p];
               drv_locked[p] <= 1'b0;
            end else if (bus_wr && PADDR == `GPM_ADDR_PAR0 + 32'(16 * p)) begin
               // Any first write spends the drive lock, even one for pull-ups only.
               // drive write once
               if (drv_locked[p]) begin
                  par[p] <= (par[p] & ~(par_mask[p] & ~`GPM_PAR_DRV_MASK))
                          | (PWDATA & par_mask[p] & ~`GPM_PAR_DRV_MASK);
               end else begin
                  par[p] <= (par[p] & ~par_mask[p]) | (PWDATA & par_mask[p]);
               end
               drv_locked[p] <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Data and direction registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         for (int p = 0; p < 3; p++) begin
            dat_ctl[p] <= 16'h0000;
         end
      end else begin
         for (int p = 0; p < 3; p++) begin
            if (soft_clear) begin
               dat_ctl[p] <= 16'h0000;
            end else if (bus_wr && PADDR == `GPM_ADDR_DAT0 + 32'(16 * p)) begin
               // Slots of missing pins stay input and low whatever is written.
               dat_ctl[p] <= PWDATA[31:16]
                           & {PIN_MASK[8*p +: 8], PIN_MASK[8*p +: 8]};
            end
         end
      end
   end

   // reset pin state
   // Recaptured on every soft reset, retained or not, so software sees the last one.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         for (int p = 0; p < 3; p++) begin
            rst_state[p] <= 8'h00;
         end
      end else if (strap_pend | SOFT_RST) begin
         for (int p = 0; p < 3; p++) begin
            rst_state[p] <= PIN_I[8*p +: 8] & PIN_MASK[8*p +: 8];
         end
      end
   end

   // ----------------------------------------------------------------
   // Input sampling
   // ----------------------------------------------------------------
   // always connected
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         PIN_IN <= 24'h00_0000;
      end else begin
         PIN_IN <= PIN_I & PIN_MASK;
      end
   end

   // Interrupt inputs exist only on four pins and only in GPIO mode.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         EXT_IRQ <= 4'h0;
      end else begin
         EXT_IRQ[0] <= PIN_I[4]  & (fsel[0][17:16] == GPM_FN_GPIO);
         EXT_IRQ[1] <= PIN_I[9]  & (fsel[1][5:4]   == GPM_FN_GPIO);
         EXT_IRQ[2] <= PIN_I[10] & (fsel[1][9:8]   == GPM_FN_GPIO);
         EXT_IRQ[3] <= PIN_I[11] & (fsel[1][13:12] == GPM_FN_GPIO);
      end
   end

   // ----------------------------------------------------------------
   // Pad drive mux
   // ----------------------------------------------------------------
   gpm_pad_t  next_pad;
   logic      next_clk_in;

   always_comb begin
      gpm_func_t fn;
      int        p;
      int        n;
      next_pad    = '0;
      next_clk_in = 1'b0;
      fn          = GPM_FN_GPIO;
      p           = 0;
      n           = 0;
      for (int i = 0; i < 24; i++) begin
         p  = i / 8;
         n  = i % 8;
         fn = gpm_func_t'(fsel[p][`GPM_PIN_STRIDE * n +: 2]);
         case (fn)
            GPM_FN_GPIO: begin
               next_pad.o[i]  = dat_ctl[p][n];
               next_pad.oe[i] = dat_ctl[p][8 + n];
            end
            GPM_FN_ALT1: begin
               next_pad.o[i]  = ALT1.o[i];
               next_pad.oe[i] = ALT1.oe[i];
            end
            GPM_FN_ALT2: begin
               next_pad.o[i]  = ALT2.o[i];
               next_pad.oe[i] = ALT2.oe[i];
            end
            default: begin
               next_pad.o[i]  = ALT3.o[i];
               next_pad.oe[i] = ALT3.oe[i];
            end
         endcase
         if (i == 10 && fn == GPM_FN_ALT2) begin
            if (PLL_CLK_MODE == `GPM_CLKMODE_EXT) begin
               // Pad released so the board clock can drive the pin.
               next_pad.o[i]  = 1'b0;
               next_pad.oe[i] = 1'b0;
               next_clk_in    = 1'b1;
            end else begin
               next_pad.o[i]  = CORE_CLK_OUT;
               next_pad.oe[i] = 1'b1;
            end
         end
         next_pad.pullup_en[i] = ~(par[p][`GPM_PIN_STRIDE * n + `GPM_PU_OFS]
                                   & par_mask[p][`GPM_PIN_STRIDE * n + `GPM_PU_OFS]);
         next_pad.drive[2*i +: 2] = par[p][`GPM_PIN_STRIDE * n + `GPM_DRV_OFS +: 2]
                                  & par_mask[p][`GPM_PIN_STRIDE * n + `GPM_DRV_OFS +: 2];
         // Unbonded slots are parked: never driven, no pull-up.
         if (!PIN_MASK[i]) begin
            next_pad.o[i]            = 1'b0;
            next_pad.oe[i]           = 1'b0;
            next_pad.pullup_en[i]    = 1'b0;
            next_pad.drive[2*i +: 2] = GPM_DRV_MEDIUM;
         end
      end
   end

   // Pad state follows the registers and the mux inputs; power saving does not touch it.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         PAD          <= '0;
         PIN12_CLK_IN <= 1'b0;
      end else begin
         PAD          <= next_pad;
         PIN12_CLK_IN <= next_clk_in;
      end
   end

endmodule : gpm_top

// *** inc/gpm_params.svh ***
// Constants of the pin mux and pad control block: addresses, layouts, reset values.
// Assumes inclusion by bare name from the package and the top module.
`ifndef GPM_PARAMS_SVH
`define GPM_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define GPM_ADDR_FSEL0    32'hFFFF_F400
`define GPM_ADDR_FSEL1    32'hFFFF_F404
`define GPM_ADDR_FSEL2    32'hFFFF_F408
`define GPM_ADDR_DAT0     32'hFFFF_F420
`define GPM_ADDR_PAR0     32'hFFFF_F42C
`define GPM_ADDR_DAT1     32'hFFFF_F430
`define GPM_ADDR_PAR1     32'hFFFF_F43C
`define GPM_ADDR_DAT2     32'hFFFF_F440
`define GPM_ADDR_PAR2     32'hFFFF_F44C
`define GPM_ADDR_RESET_CONFIGURATION   32'hFFFF_F450

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define GPM_PIN_STRIDE    4
`define GPM_PU_OFS        0
`define GPM_DRV_OFS       1
`define GPM_DIR_LSB       24
`define GPM_OUT_LSB       16
`define GPM_RSTST_LSB     8
`define GPM_IN_LSB        0
`define GPM_RETAIN_BIT    0
`define GPM_CLKMODE_EXT   2'h3

// ----------------------------------------------------------------
// Reset values and access masks
// ----------------------------------------------------------------
`define GPM_FSEL0_RST     32'h0000_1111
`define GPM_FSEL1_RST     32'h0000_0000
`define GPM_FSEL2_RST     32'h0000_0000
`define GPM_FSEL_DBG_RST  16'h1111
`define GPM_FSEL_MASK     32'h3333_3333
`define GPM_PAR0_RST      32'h2222_0000
`define GPM_PAR1_RST      32'h2200_0022
`define GPM_PAR2_RST      32'h0000_0000
`define GPM_PAR0_MASK     32'h7771_1111
`define GPM_PAR1_MASK     32'h7711_1111
`define GPM_PAR2_MASK     32'h0001_1100
`define GPM_PAR_DRV_MASK  32'h6666_6666
`define GPM_DAT_WMASK     32'hFFFF_0000
`define GPM_PIN_MASK      24'h1D_FFFF
`define GPM_RESET_CONFIGURATION_MASK   32'h0000_0001

`endif

// *** inc/gpm_pkg.sv ***
// Types shared by the pin mux and pad control block.
// Assumes gpm_params.svh on the include path.
`include "gpm_params.svh"

package gpm_pkg;

   typedef enum logic [1:0] {
      GPM_FN_GPIO = 2'h0,
      GPM_FN_ALT1 = 2'h1,
      GPM_FN_ALT2 = 2'h2,
      GPM_FN_ALT3 = 2'h3
   } gpm_func_t;

   typedef enum logic [1:0] {
      GPM_DRV_MEDIUM = 2'h0,
      GPM_DRV_LOW    = 2'h1,
      GPM_DRV_HIGH   = 2'h2
   } gpm_drive_t;

   // Pad controls, 8 slots per port, port p at bits 8p+7..8p of o, oe and pullup_en, 16p+15..16p of drive
   typedef struct packed {
      logic [23:0] o;
      logic [23:0] oe;
      logic [23:0] pullup_en;
      logic [47:0] drive;
   } gpm_pad_t;

   // One alternate function's drive onto the pins
   typedef struct packed {
      logic [23:0] o;
      logic [23:0] oe;
   } gpm_alt_t;

endpackage : gpm_pkg

// *** verification/gpm_monitor.sv ***
// Checker of the pin mux block: APB timing and pad outputs against their causes.
// Assumes it is bound onto gpm_top and sees only that module's ports.
module gpm_monitor
   import gpm_pkg::*;
#(
   parameter logic [23:0] PIN_MASK = 24'h1D_FFFF
) (
   input wire logic        CLK,
   input wire logic        RST_B,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        SOFT_RST,
   input wire logic        POWER_SAVE,
   input wire logic [1:0]  PLL_CLK_MODE,
   input wire logic        CORE_CLK_OUT,
   input wire logic [23:0] PIN_I,
   input wire gpm_alt_t    ALT1,
   input wire gpm_alt_t    ALT2,
   input wire gpm_alt_t    ALT3,
   input wire gpm_pad_t    PAD,
   input wire logic [23:0] PIN_IN,
   input wire logic [3:0]  EXT_IRQ,
   input wire logic        PIN12_CLK_IN
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   // ------------------------------------------------------------
   // Sequences
   // ------------------------------------------------------------
   sequence s_access;
      PSEL && !PENABLE ##1 PSEL && PENABLE && !PREADY;
   endsequence
   // Registers and all pad causes steady, so nothing may move
   sequence s_quiet;
      $past(RST_B, 2) && POWER_SAVE && !PSEL && !$past(PSEL) && !SOFT_RST && !$past(SOFT_RST)
         && $stable(ALT1) && $stable(ALT2) && $stable(ALT3) && $stable(CORE_CLK_OUT)
         && $stable(PLL_CLK_MODE);
   endsequence

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   AST_ONE_WAIT: assert property (s_access |=> PREADY)
      else $error("Access not answered in its second cycle");
   AST_IDLE_DATA: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
      else $error("Read data outside an answer");
   AST_ERR_PAIR: assert property (PSLVERR |-> PREADY && $past(PSEL && PENABLE))
      else $error("Error flag without an answer");
   AST_LIVE_IN: assert property ($past(RST_B) |-> PIN_IN == ($past(PIN_I) & PIN_MASK))
      else $error("Pin inputs not passed on");
   AST_IRQ_LEVEL: assert property ($past(RST_B) |-> (EXT_IRQ & ~{$past(PIN_I[11]),
      $past(PIN_I[10]), $past(PIN_I[9]), $past(PIN_I[4])}) == 4'h0)
      else $error("Interrupt input high on a low pin");
   AST_CLK_INPUT: assert property (PIN12_CLK_IN |-> $past(PLL_CLK_MODE) == 2'h3 && !PAD.oe[10])
      else $error("Clock input without external mode");
   AST_SPARE_PINS: assert property ((PAD.oe & ~PIN_MASK) == 24'h00_0000)
      else $error("Missing pin slot driven");
   AST_FIXED_DRIVE: assert property ({PAD.drive[41:38], PAD.drive[27:22], PAD.drive[9:6]} == 14'h0)
      else $error("Fixed drive field not medium");
   AST_HOLD_STATE: assert property (s_quiet |=> $stable(PAD))
      else $error("Pad state moved while idle in power save");
endmodule : gpm_monitor

// *** verification/gpm_pins_model.sv ***
// Board model of the pins: pad drivers first, then external drivers, then pull-ups.
// Assumes one pad per bit; an undriven pin without pull-up floats.
module gpm_pins_model
   import gpm_pkg::*;
(
   input  wire logic        clk,
   input  wire gpm_pad_t    pad,
   input  wire logic [23:0] ext_en,
   input  wire logic [23:0] ext_val,
   output logic      [23:0] pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [23:0] drift;
   // Floating pins change every cycle so a lost pull-up cannot pass by luck
   initial drift = 24'h55_5555;
   always @(posedge clk) drift <= ~drift;
   always_comb begin
      for (int i = 0; i < 24; i++) begin
         if (pad.oe[i]) begin
            pin[i] = pad.o[i];
         end else if (ext_en[i]) begin
            pin[i] = ext_val[i];
         end else begin
            pin[i] = pad.pullup_en[i] ? 1'b1 : drift[i];
         end
      end
   end
endmodule : gpm_pins_model

// *** verification/testbench.sv ***
// Self-checking bench of the pin mux block over APB, with a board model on the pins.
// Assumes design, package, monitor and pin model compiled before it.
`include "gpm_params.svh"
module testbench
   import gpm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic        soft_rst, power_save, core_clk, clk_in, e;
   logic [31:0] paddr, pwdata, prdata, r;
   logic [1:0]  pll_mode;
   logic [23:0] pin_i, pin_in, ext_en, ext_val;
   logic [3:0]  ext_irq;
   gpm_alt_t    alt1, alt2, alt3;
   gpm_pad_t    pad, saved;
   int          mismatches, comparisons;

   gpm_top dut_u (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SOFT_RST(soft_rst), .POWER_SAVE(power_save), .PLL_CLK_MODE(pll_mode),
      .CORE_CLK_OUT(core_clk), .PIN_I(pin_i), .ALT1(alt1), .ALT2(alt2), .ALT3(alt3),
      .PAD(pad), .PIN_IN(pin_in), .EXT_IRQ(ext_irq), .PIN12_CLK_IN(clk_in));
   gpm_pins_model pins_u (.clk(clk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pin(pin_i));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic summarize();
      if (mismatches == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         mismatches++;
         summarize();
      end
   endtask : apb
   task automatic rd(input string n, input logic [31:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk(n, r, x);
   endtask : rd
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask : settle
   task automatic soft_pulse();
      @(posedge clk);
      soft_rst <= 1'b1;
      @(posedge clk);
      soft_rst <= 1'b0;
   endtask : soft_pulse

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, soft_rst, power_save, core_clk, rst_b} = '0;
      paddr = '0;
      pwdata = '0;
      pll_mode = 2'h1;
      // Board holds strap high and a marker on port 1 through reset
      ext_en = 24'hFF_FFFF;
      ext_val = 24'h00_A501;
      alt1 = {24'h00_0000, 24'hFF_FFFF};
      alt2 = {24'hFF_FFFF, 24'h00_0000};
      alt3 = '0;
      mismatches = 0;
      comparisons = 0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      ext_en <= '0;
      rd("fsel0", `GPM_ADDR_FSEL0, 32'h0000_1111);
      rd("fsel1", `GPM_ADDR_FSEL1, 32'h0000_0000);
      rd("par0", `GPM_ADDR_PAR0, 32'h2220_0000);
      rd("par1", `GPM_ADDR_PAR1, 32'h2200_0000);
      rd("par2", `GPM_ADDR_PAR2, 32'h0000_0000);
      apb(1'b0, 32'hFFFF_F424, 32'h0000_0000);
      chk("unmapped", 32'(e), 32'h1);
      apb(1'b1, `GPM_ADDR_PAR0, 32'h0026_0001);
      apb(1'b1, `GPM_ADDR_DAT0, 32'h0000_0000);
      rd("par0 first", `GPM_ADDR_PAR0, 32'h0020_0001);
      chk("drv5", 32'(pad.drive[11:10]), 32'h1);
      apb(1'b1, `GPM_ADDR_PAR0, 32'h0040_0001);
      apb(1'b1, `GPM_ADDR_DAT0, 32'h0000_0000);
      rd("par0 again", `GPM_ADDR_PAR0, 32'h0020_0001);
      chk("drv5 kept", 32'(pad.drive[11:10]), 32'h1);
      chk("pull0", 32'(pad.pullup_en[0]), 32'h0);
      apb(1'b1, `GPM_ADDR_PAR1, 32'h4000_0000);
      apb(1'b1, `GPM_ADDR_DAT1, 32'h0000_0000);
      rd("par1 wr", `GPM_ADDR_PAR1, 32'h4000_0000);
      chk("drv15", 32'(pad.drive[31:30]), 32'h2);
      apb(1'b1, `GPM_ADDR_PAR2, 32'h0000_0100);
      apb(1'b1, `GPM_ADDR_DAT2, 32'h0000_0000);
      settle();
      chk("pull2", 32'(pad.pullup_en[20:18]), 32'h6);
      chk("pin19", 32'(pin_in[19]), 32'h1);
      apb(1'b1, `GPM_ADDR_DAT1, 32'hFFFF_0000);
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, `GPM_ADDR_FSEL1, 32'(c));
         settle();
         chk("mux p1.0", {30'h0, pad.oe[8], pad.o[8]}, 32'(3 - c));
      end
      apb(1'b1, `GPM_ADDR_FSEL1, 32'hFFFF_FFFF);
      rd("fsel1 mask", `GPM_ADDR_FSEL1, 32'h3333_3333);
      apb(1'b1, `GPM_ADDR_FSEL1, 32'h1111_1111);
      settle();
      rd("dat1 alt", `GPM_ADDR_DAT1, 32'hFFFF_A500);
      apb(1'b1, `GPM_ADDR_FSEL1, 32'h0000_0200);
      core_clk <= 1'b1;
      settle();
      chk("clk out", {30'h0, pad.oe[10], pad.o[10]}, 32'h3);
      chk("irq", 32'(ext_irq), 32'hB);
      @(posedge clk);
      pll_mode <= 2'h3;
      settle();
      chk("clk in", {30'h0, clk_in, pad.oe[10]}, 32'h2);
      saved = pad;
      @(posedge clk);
      power_save <= 1'b1;
      settle();
      settle();
      chk("hold", 32'(pad == saved), 32'h1);
      apb(1'b1, `GPM_ADDR_RESET_CONFIGURATION, 32'h0000_0001);
      apb(1'b1, `GPM_ADDR_FSEL2, 32'h0000_0001);
      soft_pulse();
      rd("retain", `GPM_ADDR_FSEL2, 32'h0000_0001);
      apb(1'b1, `GPM_ADDR_RESET_CONFIGURATION, 32'h0000_0000);
      soft_pulse();
      rd("no retain", `GPM_ADDR_FSEL2, 32'h0000_0000);
      rd("par0 dflt", `GPM_ADDR_PAR0, 32'h2220_0000);
      summarize();
   end
endmodule : testbench

bind gpm_top gpm_monitor #(.PIN_MASK(PIN_MASK)) mon_u (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE,
   .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .SOFT_RST, .POWER_SAVE, .PLL_CLK_MODE,
   .CORE_CLK_OUT, .PIN_I, .ALT1, .ALT2, .ALT3, .PAD, .PIN_IN, .EXT_IRQ, .PIN12_CLK_IN);
